// file: rtl/cpirq_pkg.sv
// Package: register map, field positions, reset values and carrier types of the interrupt control block
package cpirq_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int CPIRQ_ADDR_W = 5;
    localparam int CPIRQ_DATA_W = 32;
    localparam int CPIRQ_PORT_W = 6;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [CPIRQ_ADDR_W-1:0] OFS_CORE_CTRL = 5'h00;
    localparam logic [CPIRQ_ADDR_W-1:0] OFS_PERIPH_EN = 5'h04;
    localparam logic [CPIRQ_ADDR_W-1:0] OFS_PERIPH_FLAG = 5'h08;
    localparam logic [CPIRQ_ADDR_W-1:0] OFS_PIN_CHG_EN = 5'h0C;
    localparam logic [CPIRQ_ADDR_W-1:0] OFS_EDGE_CFG = 5'h10;
    localparam logic [CPIRQ_ADDR_W-1:0] OFS_TIMER0 = 5'h14;

    // ----------------------------------------------------------------
    // Core control and edge config field positions
    // ----------------------------------------------------------------
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_PERIPH_GATE = 6;
    localparam int BIT_T0_EN = 5;
    localparam int BIT_EXT_EN = 4;
    localparam int BIT_PORT_EN = 3;
    localparam int BIT_T0_FLAG = 2;
    localparam int BIT_EXT_FLAG = 1;
    localparam int BIT_PORT_FLAG = 0;
    localparam int BIT_EDGE_SEL = 6;

    // ----------------------------------------------------------------
    // Reset values and timer0 top count
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CORE_CTRL = 8'h00;
    localparam logic [7:0] RST_PERIPH_EN = 8'h00;
    localparam logic [7:0] RST_PERIPH_FLAG = 8'h00;
    localparam logic [CPIRQ_PORT_W-1:0] RST_PIN_CHG_EN = 6'h00;
    localparam logic RST_EDGE_SEL = 1'b1;
    localparam logic [7:0] TIMER0_TOP = 8'hFF;
    localparam logic [CPIRQ_DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {CCMODE_CAPTURE, CCMODE_COMPARE, CCMODE_PWM, CCMODE_OFF} cpirq_ccmode_t;
    typedef enum logic {BUS_IDLE, BUS_ACK} cpirq_bus_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [CPIRQ_ADDR_W-1:0] address;
        logic [CPIRQ_DATA_W-1:0] writedata;
        logic [3:0] byteenable;
    } cpirq_avs_req_t;

    // Bit order matches the peripheral enable and flag registers
    typedef struct packed {
        logic eeprom_write_done;
        logic adc_done;
        logic capcomp_event;
        logic comparator_b_out;
        logic comparator_a_out;
        logic osc_fail_status;
        logic timer2_match;
        logic timer1_overflow;
    } cpirq_periph_ev_t;

endpackage : cpirq_pkg

// file: rtl/cpirq_top.sv
// Core and peripheral interrupt enable and flag logic with an Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none

module cpirq_top (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire cpirq_pkg::cpirq_avs_req_t avs_req,
    output logic [cpirq_pkg::CPIRQ_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic timer0_tick,
    input wire logic ext_irq_pin,
    input wire logic [cpirq_pkg::CPIRQ_PORT_W-1:0] port_a_pins,
    input wire cpirq_pkg::cpirq_periph_ev_t periph_ev,
    input wire cpirq_pkg::cpirq_ccmode_t capcomp_mode,
    output logic cpu_irq_req
);
    import cpirq_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    cpirq_bus_t bus_q;
    logic wait_q;
    logic [CPIRQ_DATA_W-1:0] rdata_q;
    logic irq_q;

    logic [7:0] core_ctrl_q;
    logic [7:0] periph_en_q;
    logic [7:0] periph_flag_q;
    logic [CPIRQ_PORT_W-1:0] pin_chg_en_q;
    logic ext_edge_select_q;
    logic [7:0] timer0_count_q;

    logic primed_q;
    logic ext_prev_q;
    logic [CPIRQ_PORT_W-1:0] port_prev_q;
    logic comp_b_prev_q;
    logic comp_a_prev_q;
    logic osc_prev_q;

    logic commit_wr;
    logic [7:0] wbyte;
    logic timer0_rollover;
    logic ext_event;
    logic [CPIRQ_PORT_W-1:0] pin_changed;
    logic port_event;
    logic [7:0] periph_set;
    logic [7:0] core_flag_set;
    logic core_pending;
    logic periph_pending;
    logic [7:0] core_ctrl_d;
    logic [7:0] periph_flag_d;

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [CPIRQ_ADDR_W-1:0] addr, input logic [CPIRQ_ADDR_W-1:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    function automatic logic [CPIRQ_DATA_W-1:0] read_mux(input logic [CPIRQ_ADDR_W-1:0] addr,
                                                          input logic [7:0] core,
                                                          input logic [7:0] pen,
                                                          input logic [7:0] pflag,
                                                          input logic [CPIRQ_PORT_W-1:0] chg,
                                                          input logic edge_sel,
                                                          input logic [7:0] t0);
        logic [7:0] b;
        b = 8'h00;
        if (hit(addr, OFS_CORE_CTRL)) begin
            b = core;
        end else if (hit(addr, OFS_PERIPH_EN)) begin
            b = pen;
        end else if (hit(addr, OFS_PERIPH_FLAG)) begin
            b = pflag;
        end else if (hit(addr, OFS_PIN_CHG_EN)) begin
            b = {2'b00, chg};
        end else if (hit(addr, OFS_EDGE_CFG)) begin
            b[BIT_EDGE_SEL] = edge_sel;
        end else if (hit(addr, OFS_TIMER0)) begin
            b = t0;
        end
        read_mux = {24'h00_0000, b};
    endfunction : read_mux

    // ----------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, answer in the second cycle
    // ----------------------------------------------------------------
    // Waitrequest idles high so that every access sees exactly one wait
    // state; this keeps readdata and waitrequest straight from flops.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bus_q <= BUS_IDLE;
            wait_q <= 1'b1;
        end else begin
            unique case (bus_q)
                BUS_IDLE: begin
                    if (avs_req.read || avs_req.write) begin
                        bus_q <= BUS_ACK;
                        wait_q <= 1'b0;
                    end
                end
                BUS_ACK: begin
                    bus_q <= BUS_IDLE;
                    wait_q <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= READ_ZERO;
        end else if (bus_q == BUS_IDLE && avs_req.read) begin
            rdata_q <= read_mux(avs_req.address, core_ctrl_q, periph_en_q, periph_flag_q,
                                pin_chg_en_q, ext_edge_select_q, timer0_count_q);
        end
    end

    // Only the low byte lane carries register data
    assign commit_wr = (bus_q == BUS_ACK) && avs_req.write && avs_req.byteenable[0];
    assign wbyte = avs_req.writedata[7:0];

    // ----------------------------------------------------------------
    // Event detection
    // ----------------------------------------------------------------
    // Edge history is ignored in the first cycle after reset so that the
    // reset value of a history flop never fakes an edge.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            primed_q <= 1'b0;
            ext_prev_q <= 1'b0;
            port_prev_q <= '0;
            comp_b_prev_q <= 1'b0;
            comp_a_prev_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            primed_q <= 1'b1;
            ext_prev_q <= ext_irq_pin;
            port_prev_q <= port_a_pins;
            comp_b_prev_q <= periph_ev.comparator_b_out;
            comp_a_prev_q <= periph_ev.comparator_a_out;
            osc_prev_q <= periph_ev.osc_fail_status;
        end
    end

    // Edge polarity follows the edge select bit
    assign ext_event = primed_q && (ext_edge_select_q ? (ext_irq_pin && !ext_prev_q)
                                                      : (!ext_irq_pin && ext_prev_q));

    // Only pins with their change enable set can raise the change flag
    genvar gi;
    generate
        for (gi = 0; gi < CPIRQ_PORT_W; gi++) begin : g_pin_chg
            assign pin_changed[gi] = primed_q && pin_chg_en_q[gi]
                                     && (port_a_pins[gi] != port_prev_q[gi]);
        end
    endgenerate
    assign port_event = |pin_changed;

    assign timer0_rollover = timer0_tick && (timer0_count_q == TIMER0_TOP);

    assign periph_set[7] = periph_ev.eeprom_write_done;
    assign periph_set[6] = periph_ev.adc_done;
    assign periph_set[5] = periph_ev.capcomp_event
                           && (capcomp_mode == CCMODE_CAPTURE || capcomp_mode == CCMODE_COMPARE);
    assign periph_set[4] = primed_q && (periph_ev.comparator_b_out != comp_b_prev_q);
    assign periph_set[3] = primed_q && (periph_ev.comparator_a_out != comp_a_prev_q);
    assign periph_set[2] = primed_q && periph_ev.osc_fail_status && !osc_prev_q;
    assign periph_set[1] = periph_ev.timer2_match;
    assign periph_set[0] = periph_ev.timer1_overflow;

    always_comb begin
        core_flag_set = 8'h00;
        core_flag_set[BIT_T0_FLAG] = timer0_rollover;
        core_flag_set[BIT_EXT_FLAG] = ext_event;
        core_flag_set[BIT_PORT_FLAG] = port_event;
    end

    // ----------------------------------------------------------------
    // Timer0 count
    // ----------------------------------------------------------------
    // Deliberately not reset: the count survives reset and reads unknown
    // until software loads it.
    always_ff @(posedge clk_sys) begin
        if (commit_wr && hit(avs_req.address, OFS_TIMER0)) begin
            timer0_count_q <= wbyte;
        end else if (timer0_tick) begin
            timer0_count_q <= timer0_count_q + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Control and flag registers
    // ----------------------------------------------------------------
    // A flag set in the same cycle as a software write of zero stays set;
    // hardware only ever ORs flags in.
    always_comb begin
        core_ctrl_d = core_ctrl_q;
        if (commit_wr && hit(avs_req.address, OFS_CORE_CTRL)) begin
            core_ctrl_d = wbyte;
        end
        core_ctrl_d = core_ctrl_d | core_flag_set;
    end

    always_comb begin
        periph_flag_d = periph_flag_q;
        if (commit_wr && hit(avs_req.address, OFS_PERIPH_FLAG)) begin
            periph_flag_d = wbyte;
        end
        periph_flag_d = periph_flag_d | periph_set;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            core_ctrl_q <= RST_CORE_CTRL;
        end else begin
            core_ctrl_q <= core_ctrl_d;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            periph_flag_q <= RST_PERIPH_FLAG;
        end else begin
            periph_flag_q <= periph_flag_d;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            periph_en_q <= RST_PERIPH_EN;
        end else if (commit_wr && hit(avs_req.address, OFS_PERIPH_EN)) begin
            periph_en_q <= wbyte;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pin_chg_en_q <= RST_PIN_CHG_EN;
        end else if (commit_wr && hit(avs_req.address, OFS_PIN_CHG_EN)) begin
            pin_chg_en_q <= wbyte[CPIRQ_PORT_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ext_edge_select_q <= RST_EDGE_SEL;
        end else if (commit_wr && hit(avs_req.address, OFS_EDGE_CFG)) begin
            ext_edge_select_q <= wbyte[BIT_EDGE_SEL];
        end
    end

    // ----------------------------------------------------------------
    // Combined request
    // ----------------------------------------------------------------
    // Request is computed from the registered flags, so it lags a flag by
    // one cycle; a stale flag left set fires as soon as its enable is set.
    assign core_pending = (core_ctrl_q[BIT_T0_EN] && core_ctrl_q[BIT_T0_FLAG])
                          || (core_ctrl_q[BIT_EXT_EN] && core_ctrl_q[BIT_EXT_FLAG])
                          || (core_ctrl_q[BIT_PORT_EN] && core_ctrl_q[BIT_PORT_FLAG]);
    assign periph_pending = core_ctrl_q[BIT_PERIPH_GATE] && |(periph_en_q & periph_flag_q);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= core_ctrl_q[BIT_GLOBAL_EN] && (core_pending || periph_pending);
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign cpu_irq_req = irq_q;

endmodule : cpirq_top

`default_nettype wire

// file: testbench/cpirq_src_model.sv
// Event source model standing in for the peripherals that feed the interrupt block
`timescale 1ns/100ps
`default_nettype none

module cpirq_src_model (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] fire,
    output cpirq_pkg::cpirq_periph_ev_t periph_ev
);
    import cpirq_pkg::*;

    // Comparator outputs are levels, so a fire toggles them; every other source is a one-cycle pulse
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            periph_ev <= '0;
        end else begin
            periph_ev <= {fire[7:5], periph_ev[4:3] ^ fire[4:3], fire[2:0]};
        end
    end
endmodule : cpirq_src_model

`default_nettype wire

// file: testbench/cpirq_top_sva.sv
// Port-level assertion checker for the interrupt control block
`timescale 1ns/100ps
`default_nettype none

module cpirq_top_sva (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire cpirq_pkg::cpirq_avs_req_t avs_req,
    input wire logic [cpirq_pkg::CPIRQ_DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic timer0_tick,
    input wire logic ext_irq_pin,
    input wire logic [cpirq_pkg::CPIRQ_PORT_W-1:0] port_a_pins,
    input wire cpirq_pkg::cpirq_periph_ev_t periph_ev,
    input wire cpirq_pkg::cpirq_ccmode_t capcomp_mode,
    input wire logic cpu_irq_req
);
    import cpirq_pkg::*;

    // Shadows of the enable registers, rebuilt from committed bus writes
    logic [7:0] core_q;
    logic [7:0] pen_q;
    logic wr_ok;
    assign wr_ok = avs_req.write && !avs_waitrequest && avs_req.byteenable[0];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            core_q <= 8'h00;
        end else if (wr_ok && avs_req.address == OFS_CORE_CTRL) begin
            core_q <= avs_req.writedata[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pen_q <= 8'h00;
        end else if (wr_ok && avs_req.address == OFS_PERIPH_EN) begin
            pen_q <= avs_req.writedata[7:0];
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence bus_done;
        !avs_waitrequest;
    endsequence
    sequence periph_hit;
        core_q[7] && core_q[6] && ((periph_ev & pen_q & 8'hC3) != 8'h00) && !avs_req.write;
    endsequence

    wait_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("wait low for more than one cycle");
    req_answer_a: assert property ($rose(avs_req.read || avs_req.write) |=> bus_done)
        else $error("access not answered after one wait cycle");
    read_upper_a: assert property (bus_done |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    unmapped_read_a: assert property (avs_req.read && !avs_waitrequest && avs_req.address > OFS_TIMER0
        |-> avs_readdata == READ_ZERO) else $error("unmapped read not zero");
    global_gate_a: assert property (!core_q[7] |=> !cpu_irq_req)
        else $error("request while global enable clear");
    periph_gate_a: assert property (!core_q[6] && core_q[5:3] == 3'b000 |=> !cpu_irq_req)
        else $error("peripheral request while gate clear");
    periph_irq_a: assert property (periph_hit |-> ##2 cpu_irq_req)
        else $error("enabled peripheral event gave no request");
    pwm_block_a: assert property (capcomp_mode == CCMODE_PWM && periph_ev.capcomp_event && pen_q == 8'h20
        && core_q[5:3] == 3'b000 && !cpu_irq_req && !avs_req.write |-> ##2 !cpu_irq_req) else $error("capcomp in pwm");
    irq_hold_a: assert property ($fell(cpu_irq_req) |-> $past(wr_ok, 2))
        else $error("request dropped without a write");
endmodule : cpirq_top_sva

bind cpirq_top cpirq_top_sva u_sva (.clk_sys(clk_sys), .nrst(nrst), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timer0_tick(timer0_tick),
    .ext_irq_pin(ext_irq_pin), .port_a_pins(port_a_pins), .periph_ev(periph_ev),
    .capcomp_mode(capcomp_mode), .cpu_irq_req(cpu_irq_req));

`default_nettype wire

// file: testbench/cpirq_top_tb.sv
// Self-checking testbench for the interrupt control block
`timescale 1ns/100ps
`default_nettype none

module cpirq_top_tb;
    import cpirq_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    cpirq_avs_req_t avs_req = '0;
    logic [CPIRQ_DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic timer0_tick = 1'b0;
    logic ext_irq_pin = 1'b0;
    logic [CPIRQ_PORT_W-1:0] port_a_pins = 6'h00;
    logic [7:0] fire = 8'h00;
    cpirq_periph_ev_t periph_ev;
    cpirq_ccmode_t capcomp_mode = CCMODE_CAPTURE;
    logic cpu_irq_req;
    logic [7:0] rd;
    int error_cnt = 0;
    int n_compared = 0;

    always #4 clk_sys = ~clk_sys;

    cpirq_top dut (.clk_sys(clk_sys), .nrst(nrst), .avs_req(avs_req), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer0_tick(timer0_tick), .ext_irq_pin(ext_irq_pin),
        .port_a_pins(port_a_pins), .periph_ev(periph_ev), .capcomp_mode(capcomp_mode), .cpu_irq_req(cpu_irq_req));
    cpirq_src_model u_src (.clk_sys(clk_sys), .nrst(nrst), .fire(fire), .periph_ev(periph_ev));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // Request held until waitrequest is sampled low; one idle cycle between accesses
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge clk_sys);
        avs_req.write <= w;
        avs_req.read <= !w;
        avs_req.address <= a;
        avs_req.writedata <= {24'h00_0000, d};
        avs_req.byteenable <= be;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        rd = avs_readdata[7:0];
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask : wr

    task automatic rdchk(input string what, input logic [4:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00, 4'h0);
        chk(what, 32'(rd), 32'(exp));
    endtask : rdchk

    task automatic irqchk(input logic [7:0] core, input logic e);
        wr(OFS_CORE_CTRL, core);
        cyc(2);
        chk("irq", 32'(cpu_irq_req), 32'(e));
    endtask : irqchk

    task automatic pulse(input logic [7:0] m);
        @(posedge clk_sys);
        fire <= m;
        @(posedge clk_sys);
        fire <= 8'h00;
        cyc(3);
    endtask : pulse

    // A tick is a one-cycle pulse; held high it would count once per cycle
    task automatic drive(input logic t, input logic e, input logic [5:0] p);
        @(posedge clk_sys);
        timer0_tick <= t;
        ext_irq_pin <= e;
        port_a_pins <= p;
        @(posedge clk_sys);
        timer0_tick <= 1'b0;
        cyc(2);
    endtask : drive

    task automatic give_verdict();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        cyc(20000);
        error_cnt++;
        give_verdict();
    end

    initial begin
        cyc(4);
        nrst <= 1'b1;
        cyc(2);
        rdchk("core_rst", OFS_CORE_CTRL, 8'h00);
        rdchk("pen_rst", OFS_PERIPH_EN, 8'h00);
        rdchk("pflag_rst", OFS_PERIPH_FLAG, 8'h00);
        rdchk("pinen_rst", OFS_PIN_CHG_EN, 8'h00);
        rdchk("edge_rst", OFS_EDGE_CFG, 8'h40);
        wr(5'h18, 8'hFF);
        rdchk("unmapped", 5'h18, 8'h00);
        bus(1'b1, OFS_PERIPH_EN, 8'hFF, 4'h0);
        rdchk("pen_be", OFS_PERIPH_EN, 8'h00);
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            rdchk("pflag_set", OFS_PERIPH_FLAG, 8'h01 << i);
            cyc(4);
            rdchk("pflag_held", OFS_PERIPH_FLAG, 8'h01 << i);
            wr(OFS_PERIPH_FLAG, 8'h00);
        end
        wr(OFS_PERIPH_EN, 8'h20);
        irqchk(8'hC0, 1'b0);
        for (int m = 1; m < 4; m++) begin
            @(posedge clk_sys);
            capcomp_mode <= cpirq_ccmode_t'(m);
            pulse(8'h20);
            chk("cc_irq", 32'(cpu_irq_req), 32'(m == 1));
            rdchk("cc_flag", OFS_PERIPH_FLAG, (m == 1) ? 8'h20 : 8'h00);
            irqchk(8'hC0, m == 1);
            wr(OFS_PERIPH_FLAG, 8'h00);
        end
        wr(OFS_PERIPH_EN, 8'h02);
        irqchk(8'h00, 1'b0);
        pulse(8'h02);
        irqchk(8'h80, 1'b0);
        irqchk(8'h40, 1'b0);
        irqchk(8'hC0, 1'b1);
        wr(OFS_PERIPH_FLAG, 8'h00);
        irqchk(8'hC0, 1'b0);
        pulse(8'h02);
        chk("irq_direct", 32'(cpu_irq_req), 32'h0000_0001);
        wr(OFS_PERIPH_EN, 8'h00);
        irqchk(8'h00, 1'b0);
        wr(OFS_TIMER0, 8'hFE);
        drive(1'b1, 1'b0, 6'h00);
        rdchk("t0_nowrap", OFS_CORE_CTRL, 8'h00);
        @(posedge clk_sys);
        timer0_tick <= 1'b1;
        drive(1'b0, 1'b0, 6'h00);
        rdchk("t0_count", OFS_TIMER0, 8'h00);
        rdchk("t0_flag", OFS_CORE_CTRL, 8'h04);
        irqchk(8'hA4, 1'b1);
        irqchk(8'h00, 1'b0);
        drive(1'b0, 1'b1, 6'h00);
        rdchk("ext_rise", OFS_CORE_CTRL, 8'h02);
        irqchk(8'h92, 1'b1);
        wr(OFS_CORE_CTRL, 8'h00);
        drive(1'b0, 1'b0, 6'h00);
        rdchk("ext_fall_ign", OFS_CORE_CTRL, 8'h00);
        wr(OFS_EDGE_CFG, 8'h00);
        drive(1'b0, 1'b1, 6'h00);
        rdchk("ext_rise_ign", OFS_CORE_CTRL, 8'h00);
        drive(1'b0, 1'b0, 6'h00);
        rdchk("ext_fall", OFS_CORE_CTRL, 8'h02);
        wr(OFS_CORE_CTRL, 8'h00);
        drive(1'b0, 1'b0, 6'h01);
        rdchk("port_masked", OFS_CORE_CTRL, 8'h00);
        wr(OFS_PIN_CHG_EN, 8'h20);
        drive(1'b0, 1'b0, 6'h21);
        rdchk("port_chg", OFS_CORE_CTRL, 8'h01);
        irqchk(8'h09, 1'b0);
        irqchk(8'h89, 1'b1);
        wr(OFS_TIMER0, 8'h5A);
        @(posedge clk_sys);
        nrst <= 1'b0;
        cyc(4);
        nrst <= 1'b1;
        cyc(2);
        rdchk("t0_keep", OFS_TIMER0, 8'h5A);
        rdchk("core_rst2", OFS_CORE_CTRL, 8'h00);
        give_verdict();
    end
endmodule : cpirq_top_tb

`default_nettype wire
